// file: hw/idp_datapath.v
// Integer and fractional execution datapath with registered result and flags
// Operation
// [RULE1] Magnitude and difference magnitude, each with a clamping variant.
// [RULE2] Smaller/larger of two operands, signed or unsigned compare.
// [RULE3] Clamp a 32-bit value to byte or halfword range.
// [RULE4] Condition register non-zero means true, zero means false.
// [RULE5] Conditional add/subtract act on true; negated forms act on false.
// [RULE6] Select writes first source if condition true, else second.
// [RULE7] AND, OR, XOR, their inversions, and AND/OR with inverted b.
// [RULE8] Leading zero or one count from the top, 0 if top differs.
// [RULE9] Redundant sign count equals leading sign bits minus one.
// [RULE10] All-zero gives 32 zeros, all-ones 32 ones, sign count 31.
// [RULE11] Signed amount: left by n[4:0], else right by (-n)[4:0].
// [RULE12] Logical fills zeros; arithmetic fills sign on right shifts.
// [RULE13] Clamping shift saturates when shifted-out bits differ from sign.
// [RULE14] Unsigned field extract of w bits at pos, upper bits zero.
// [RULE15] Signed field extract extends the field's top bit upward.
// [RULE16] Pair window: 64-bit concat shifted left by pos, upper word.
// [RULE17] Insert w low bits or 4-bit constant at pos, rest kept.
// [RULE18] Fractions are 1.15 in upper half or 1.31 signed.
// [RULE19] Product shifted left by one, or kept in 2.30 form.
// [RULE20] Minus one squared, shifted, gives max positive, no overflow; with round_en the code rounds it up to 0x80000000 before any clamp.
// [RULE21] Rounding forms add one at bit 15 of the result.
// [RULE22] Multiply forms clamp on signed or unsigned overflow.
// [RULE23] Sticky near-overflow flag holds until software clears it.
// [RULE24] Near-overflow is XOR of the two top result bits.
// [RULE25] Signed clamp bounds 2^31-1 and -2^31; unsigned lower bound zero.
// [RULE26] Unperformed conditional add/subtract returns the first source.
`timescale 1ns/10ps
`include "idp_defines.vh"
module idp_datapath (
  input wire ref_clk,
  input wire rst_n,
  input wire issue,
  input wire [5:0] op,
  input wire [31:0] src_a,
  input wire [31:0] src_b,
  input wire [31:0] src_c,
  input wire [31:0] cond_val,
  input wire [4:0] pos,
  input wire [5:0] width,
  input wire [3:0] konst,
  input wire frac_shift,
  input wire round_en,
  input wire [1:0] mul_clamp,
  input wire flag_clear,
  output reg [31:0] result,
  output reg result_valid,
  output reg overflow,
  output reg near_overflow_flag,
  output reg sticky_near_overflow_flag
);
  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  function [31:0] field_mask;
    input [5:0] w;
    begin
      if (w >= 6'h20) begin
        field_mask = 32'hffffffff;
      end else begin
        field_mask = ~(32'hffffffff << w);
      end
    end
  endfunction

  function [31:0] clamp_signed;
    input [32:0] v;
    begin
      if (!v[32] && v[31]) begin
        clamp_signed = `IDP_SMAX32; // [RULE25]
      end else if (v[32] && !v[31]) begin
        clamp_signed = `IDP_SMIN32; // [RULE25]
      end else begin
        clamp_signed = v[31:0];
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Arithmetic building blocks
  wire cond_true = |cond_val; // [RULE4]
  wire [32:0] a_ext = {src_a[31], src_a};
  wire [32:0] b_ext = {src_b[31], src_b};
  wire [32:0] neg_a = 33'h0 - a_ext;
  wire [32:0] diff = a_ext - b_ext;
  wire [32:0] mag_a = src_a[31] ? neg_a : a_ext;
  wire [32:0] mag_d = diff[32] ? (33'h0 - diff) : diff;
  wire s_lt = $signed(src_a) < $signed(src_b);
  wire u_lt = src_a < src_b;
  wire [31:0] sum_ab = src_a + src_b;
  wire [31:0] dif_ab = src_a - src_b;

  // Zero-run and one-run counters differ only in the fill level
  wire [11:0] lead_cnt;
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_lead
      idp_lead_count #(
        .WIDTH(32)
      ) idp_lead_count_inst (
        .value(src_a),
        .fill(g == 1),
        .count(lead_cnt[g*6 +: 6])
      );
    end
  endgenerate

  wire [5:0] lz_cnt = lead_cnt[5:0];
  wire [5:0] lo_cnt = lead_cnt[11:6];
  wire [5:0] sign_run = src_a[31] ? lo_cnt : lz_cnt;

  ////////////////////////////////////////////////////////////////////////////
  // Shifter
  wire amt_neg = src_b[31];
  wire [31:0] neg_b = 32'h00000000 - src_b;
  wire [4:0] amt = amt_neg ? neg_b[4:0] : src_b[4:0]; // [RULE11]
  wire [31:0] shl = src_a << amt; // [RULE12]
  wire [31:0] shr_l = src_a >> amt; // [RULE12]
  wire [31:0] shr_a = $signed(src_a) >>> amt; // [RULE12]
  wire [63:0] shl_wide = {{32{src_a[31]}}, src_a} << amt;
  // Bits above the result must all equal the result sign
  wire shl_lost = (shl_wide[63:31] != {33{shl_wide[31]}}); // [RULE13]

  ////////////////////////////////////////////////////////////////////////////
  // Bit fields
  wire [31:0] fmask = field_mask(width);
  wire [31:0] pulled = (src_a >> pos) & fmask; // [RULE14]
  wire [5:0] top_idx = width - 6'h01;
  wire field_top = (width == 6'h00) ? 1'b0 : pulled[top_idx[4:0]];
  wire [31:0] pulled_s = field_top ? (pulled | ~fmask) : pulled; // [RULE15]
  wire [63:0] window = {src_a, src_b} << pos; // [RULE16]
  wire [31:0] ins_val = (op == `IDP_OP_INSERT_K) ? {28'h0000000, konst} : src_b; // [RULE17]
  wire [31:0] ins_mask = fmask << pos;
  wire [31:0] inserted = (src_a & ~ins_mask) | ((ins_val << pos) & ins_mask); // [RULE17]

  ////////////////////////////////////////////////////////////////////////////
  // Fractional multiply
  wire [63:0] prod = $signed({{32{src_a[31]}}, src_a}) * $signed({{32{src_b[31]}}, src_b});
  wire minus_one_sq = (src_a == `IDP_SMIN32) && (src_b == `IDP_SMIN32);
  // 1.31 x 1.31 gives 2.62; upper word is 2.30, one left shift gives 1.31
  wire [31:0] q_unshifted = prod[63:32]; // [RULE19]
  wire [31:0] q_shifted = prod[62:31]; // [RULE19]
  wire half_mm = (src_a[31:16] == 16'h8000) && (src_b[31:16] == 16'h8000) &&
                 ~|src_a[15:0] && ~|src_b[15:0]; // [RULE18]
  // Minus one squared would wrap to minus one once shifted
  reg [31:0] q_base;
  always @* begin
    if (!frac_shift) begin
      q_base = q_unshifted; // [RULE19]
    end else if (minus_one_sq || half_mm) begin
      q_base = `IDP_SMAX32; // [RULE20]
    end else begin
      q_base = q_shifted; // [RULE19]
    end
  end
  wire [32:0] acc_ext = {src_c[31], src_c};
  wire [32:0] qb_ext = {q_base[31], q_base};
  reg [32:0] q_sum;
  always @* begin
    case (op)
      `IDP_OP_QMAC: q_sum = acc_ext + qb_ext;
      `IDP_OP_QMSB: q_sum = acc_ext - qb_ext;
      default: q_sum = qb_ext;
    endcase
  end
  wire [32:0] q_rnd = round_en ? (q_sum + {1'b0, `IDP_ROUND_BIT}) : q_sum; // [RULE21]
  wire [32:0] q_trunc = round_en ? (q_rnd & {1'b1, `IDP_FRAC_HI}) : q_rnd;
  reg [31:0] q_out;
  reg q_ovf;
  always @* begin
    q_out = q_trunc[31:0];
    q_ovf = q_trunc[32] != q_trunc[31];
    case (mul_clamp)
      `IDP_MUL_CLAMP_S: q_out = clamp_signed(q_trunc); // [RULE22]
      `IDP_MUL_CLAMP_U: begin
        if (q_trunc[32]) begin
          q_out = 32'h00000000; // [RULE25]
          q_ovf = 1'b1;
        end else begin
          q_out = q_trunc[31:0];
          q_ovf = 1'b0;
        end
      end
      default: q_out = q_trunc[31:0];
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Result select
  reg [31:0] res_d;
  reg ovf_d;
  always @* begin
    res_d = 32'h00000000;
    ovf_d = 1'b0;
    case (op)
      `IDP_OP_MAG: begin
        res_d = mag_a[31:0]; // [RULE1]
        ovf_d = mag_a[32] != mag_a[31];
      end
      `IDP_OP_MAG_CLAMP: begin
        res_d = clamp_signed(mag_a); // [RULE1]
        ovf_d = mag_a[32] != mag_a[31];
      end
      `IDP_OP_DMAG: begin
        res_d = mag_d[31:0]; // [RULE1]
        ovf_d = mag_d[32] != mag_d[31];
      end
      `IDP_OP_DMAG_CLAMP: begin
        res_d = clamp_signed(mag_d); // [RULE1]
        ovf_d = mag_d[32] != mag_d[31];
      end
      `IDP_OP_MIN: res_d = s_lt ? src_a : src_b; // [RULE2]
      `IDP_OP_MAX: res_d = s_lt ? src_b : src_a; // [RULE2]
      `IDP_OP_MIN_U: res_d = u_lt ? src_a : src_b; // [RULE2]
      `IDP_OP_MAX_U: res_d = u_lt ? src_b : src_a; // [RULE2]
      `IDP_OP_CLAMP_B: begin
        if ($signed(src_a) > $signed(`IDP_SMAX8)) begin
          res_d = `IDP_SMAX8; // [RULE3]
        end else if ($signed(src_a) < $signed(`IDP_SMIN8)) begin
          res_d = `IDP_SMIN8; // [RULE3]
        end else begin
          res_d = src_a;
        end
      end
      `IDP_OP_CLAMP_BU: res_d = (src_a > `IDP_UMAX8) ? `IDP_UMAX8 : src_a; // [RULE3]
      `IDP_OP_CLAMP_H: begin
        if ($signed(src_a) > $signed(`IDP_SMAX16)) begin
          res_d = `IDP_SMAX16; // [RULE3]
        end else if ($signed(src_a) < $signed(`IDP_SMIN16)) begin
          res_d = `IDP_SMIN16; // [RULE3]
        end else begin
          res_d = src_a;
        end
      end
      `IDP_OP_CLAMP_HU: res_d = (src_a > `IDP_UMAX16) ? `IDP_UMAX16 : src_a; // [RULE3]
      `IDP_OP_CACC: res_d = cond_true ? sum_ab : src_a; // [RULE5] [RULE26]
      `IDP_OP_CDED: res_d = cond_true ? dif_ab : src_a; // [RULE5] [RULE26]
      `IDP_OP_CACC_F: res_d = cond_true ? src_a : sum_ab; // [RULE5] [RULE26]
      `IDP_OP_CDED_F: res_d = cond_true ? src_a : dif_ab; // [RULE5] [RULE26]
      `IDP_OP_SELECT: res_d = cond_true ? src_a : src_b; // [RULE6]
      `IDP_OP_AND: res_d = src_a & src_b; // [RULE7]
      `IDP_OP_OR: res_d = src_a | src_b; // [RULE7]
      `IDP_OP_XOR: res_d = src_a ^ src_b; // [RULE7]
      `IDP_OP_NAND: res_d = ~(src_a & src_b); // [RULE7]
      `IDP_OP_NOR: res_d = ~(src_a | src_b); // [RULE7]
      `IDP_OP_XNOR: res_d = ~(src_a ^ src_b); // [RULE7]
      `IDP_OP_AND_WITH_INVERTED_B: res_d = src_a & ~src_b; // [RULE7]
      `IDP_OP_ORN: res_d = src_a | ~src_b; // [RULE7]
      `IDP_OP_LZC: res_d = {26'h0, lz_cnt}; // [RULE8] [RULE10]
      `IDP_OP_LOC: res_d = {26'h0, lo_cnt}; // [RULE8] [RULE10]
      `IDP_OP_RSC: res_d = {26'h0, sign_run - 6'h01}; // [RULE9] [RULE10]
      `IDP_OP_LSH: res_d = amt_neg ? shr_l : shl; // [RULE11] [RULE12]
      `IDP_OP_ASH: res_d = amt_neg ? shr_a : shl; // [RULE11] [RULE12]
      `IDP_OP_ASH_CLAMP: begin
        if (amt_neg) begin
          res_d = shr_a;
        end else if (shl_lost) begin
          res_d = src_a[31] ? `IDP_SMIN32 : `IDP_SMAX32; // [RULE13] [RULE25]
          ovf_d = 1'b1;
        end else begin
          res_d = shl;
        end
      end
      `IDP_OP_PULL_U: res_d = pulled; // [RULE14]
      `IDP_OP_PULL_S: res_d = pulled_s; // [RULE15]
      `IDP_OP_WINDOW: res_d = window[63:32]; // [RULE16]
      `IDP_OP_INSERT, `IDP_OP_INSERT_K: res_d = inserted; // [RULE17]
      `IDP_OP_QMUL, `IDP_OP_QMAC, `IDP_OP_QMSB: begin
        res_d = q_out;
        ovf_d = q_ovf;
      end
      default: res_d = 32'h00000000;
    endcase
  end
  // Near-overflow is taken at word width for every operation
  wire near_d = res_d[31] ^ res_d[30]; // [RULE24]

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      result <= 32'h00000000;
      result_valid <= 1'b0;
      overflow <= 1'b0;
      near_overflow_flag <= 1'b0;
      sticky_near_overflow_flag <= 1'b0;
    end else begin
      result_valid <= issue;
      if (issue) begin
        result <= res_d;
        overflow <= ovf_d;
        near_overflow_flag <= near_d;
      end
      // Setting event wins over a same-cycle clear
      if (issue && near_d) begin
        sticky_near_overflow_flag <= 1'b1; // [RULE23]
      end else if (flag_clear) begin
        sticky_near_overflow_flag <= 1'b0; // [RULE23]
      end
    end
  end
endmodule // idp_datapath

// file: hw/idp_defines.vh
// Opcode encodings, multiply clamp modes and constants for the integer/DSP datapath
`ifndef IDP_DEFINES_VH
`define IDP_DEFINES_VH
`define IDP_OP_W 6
`define IDP_OP_MAG 6'h00
`define IDP_OP_MAG_CLAMP 6'h01
`define IDP_OP_DMAG 6'h02
`define IDP_OP_DMAG_CLAMP 6'h03
`define IDP_OP_MIN 6'h04
`define IDP_OP_MAX 6'h05
`define IDP_OP_MIN_U 6'h06
`define IDP_OP_MAX_U 6'h07
`define IDP_OP_CLAMP_B 6'h08
`define IDP_OP_CLAMP_BU 6'h09
`define IDP_OP_CLAMP_H 6'h0a
`define IDP_OP_CLAMP_HU 6'h0b
`define IDP_OP_CACC 6'h0c
`define IDP_OP_CDED 6'h0d
`define IDP_OP_CACC_F 6'h0e
`define IDP_OP_CDED_F 6'h0f
`define IDP_OP_SELECT 6'h10
`define IDP_OP_AND 6'h11
`define IDP_OP_OR 6'h12
`define IDP_OP_XOR 6'h13
`define IDP_OP_NAND 6'h14
`define IDP_OP_NOR 6'h15
`define IDP_OP_XNOR 6'h16
`define IDP_OP_AND_WITH_INVERTED_B 6'h17
`define IDP_OP_ORN 6'h18
`define IDP_OP_LZC 6'h19
`define IDP_OP_LOC 6'h1a
`define IDP_OP_RSC 6'h1b
`define IDP_OP_LSH 6'h1c
`define IDP_OP_ASH 6'h1d
`define IDP_OP_ASH_CLAMP 6'h1e
`define IDP_OP_PULL_U 6'h1f
`define IDP_OP_PULL_S 6'h20
`define IDP_OP_WINDOW 6'h21
`define IDP_OP_INSERT 6'h22
`define IDP_OP_INSERT_K 6'h23
`define IDP_OP_QMUL 6'h24
`define IDP_OP_QMAC 6'h25
`define IDP_OP_QMSB 6'h26
`define IDP_MUL_S 2'h0
`define IDP_MUL_CLAMP_S 2'h1
`define IDP_MUL_CLAMP_U 2'h2
`define IDP_SMAX32 32'h7fffffff
`define IDP_SMIN32 32'h80000000
`define IDP_UMAX32 32'hffffffff
`define IDP_SMAX8 32'h0000007f
`define IDP_SMIN8 32'hffffff80
`define IDP_UMAX8 32'h000000ff
`define IDP_SMAX16 32'h00007fff
`define IDP_SMIN16 32'hffff8000
`define IDP_UMAX16 32'h0000ffff
`define IDP_FRAC_HI 32'hffff0000
`define IDP_ROUND_BIT 32'h00008000
`define IDP_LEAD_ALL 6'h20
`define IDP_SIGN_ALL 6'h1f
`endif

// file: hw/idp_lead_count.v
// Leading-bit counter: counts bits equal to the fill level from the top
`timescale 1ns/10ps
module idp_lead_count #(
  parameter WIDTH = 32
) (
  input wire [WIDTH-1:0] value,
  input wire fill,
  output reg [5:0] count
);
  integer i;
  reg run;
  always @* begin
    count = 6'h00;
    run = 1'b1;
    for (i = WIDTH - 1; i >= 0; i = i - 1) begin
      if (run && (value[i] == fill)) begin
        count = count + 6'h01;
      end else begin
        run = 1'b0;
      end
    end
  end
endmodule // idp_lead_count

// file: verification/idp_core_model.sv
// Stimulus model driving opcode and operands into the datapath
`timescale 1ns/10ps
module idp_core_model (
  input wire ref_clk,
  input wire [31:0] result,
  input wire result_valid,
  output reg issue,
  output reg [5:0] op,
  output reg [31:0] src_a,
  output reg [31:0] src_b,
  output reg [31:0] src_c,
  output reg [31:0] cond_val,
  output reg [4:0] pos,
  output reg [5:0] width,
  output reg [3:0] konst,
  output reg frac_shift,
  output reg round_en,
  output reg [1:0] mul_clamp,
  output reg flag_clear
);
  reg [31:0] res;
  reg late;
  // Called once by the bench so that one process drives every output
  task init;
    begin
      {issue, op, src_a, src_b, src_c, cond_val, pos, width, konst} = 150'h0;
      {frac_shift, round_en, mul_clamp, flag_clear, late} = 6'h00;
    end
  endtask
  // Operands scrambled once the issuing edge has passed
  task go(input [5:0] o, input [31:0] a, input [31:0] b);
    begin
      repeat (late ? 3 : 1) @(negedge ref_clk);
      op = o;
      src_a = a;
      src_b = b;
      issue = 1'b1;
      @(negedge ref_clk);
      issue = 1'b0;
      src_a = ~a;
      src_b = ~b;
      res = result_valid ? result : 32'hxxxxxxxx;
    end
  endtask
endmodule // idp_core_model

// file: verification/idp_monitor.sv
// Port checker for the integer datapath
`timescale 1ns/10ps
`include "idp_defines.vh"
module idp_monitor (
  input wire ref_clk,
  input wire rst_n,
  input wire issue,
  input wire [5:0] op,
  input wire [31:0] src_a,
  input wire [31:0] src_b,
  input wire [31:0] cond_val,
  input wire frac_shift,
  input wire round_en,
  input wire flag_clear,
  input wire [31:0] result,
  input wire result_valid,
  input wire overflow,
  input wire near_overflow_flag,
  input wire sticky_near_overflow_flag
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  wire a_lt = $signed(src_a) < $signed(src_b);
  wire neg_sq = src_a == `IDP_SMIN32 && src_b == `IDP_SMIN32 && frac_shift && !round_en;
  ////////////////////////////////////////
  a_logic_and: assert property (issue && op == `IDP_OP_AND
    |=> result == ($past(src_a) & $past(src_b)))
    else $error("and result wrong");
  a_select_pick: assert property (issue && op == `IDP_OP_SELECT
    |=> result == ($past(cond_val) != 32'h0 ? $past(src_a) : $past(src_b)))
    else $error("select picked wrong source");
  a_cond_skip: assert property (issue && op == `IDP_OP_CACC && cond_val == 32'h0
    |=> result == $past(src_a))
    else $error("skipped add changed value");
  a_cond_deduct: assert property (issue && op == `IDP_OP_CDED && cond_val != 32'h0
    |=> result == $past(src_a) - $past(src_b))
    else $error("conditional subtract wrong");
  a_min_signed: assert property (issue && op == `IDP_OP_MIN
    |=> result == ($past(a_lt) ? $past(src_a) : $past(src_b)))
    else $error("signed minimum wrong");
  a_lead_top: assert property (issue && op == `IDP_OP_LZC && src_a[31]
    |=> result == 32'h0)
    else $error("leading zero count not zero");
  a_neg_square: assert property (issue && op == `IDP_OP_QMUL && neg_sq
    |=> result == `IDP_SMAX32 && !overflow)
    else $error("minus one squared wrong");
  a_near_xor: assert property (result_valid
    |-> near_overflow_flag == (result[31] ^ result[30]))
    else $error("near flag mismatch");
  a_sticky_hold: assert property (sticky_near_overflow_flag && !flag_clear
    |=> sticky_near_overflow_flag)
    else $error("sticky flag dropped");
  a_sticky_set: assert property (result_valid && near_overflow_flag
    |-> sticky_near_overflow_flag)
    else $error("sticky flag not set");
  c_neg_square: cover property (issue && op == `IDP_OP_QMUL && neg_sq);
  c_sticky: cover property ($rose(sticky_near_overflow_flag));
  c_skip: cover property (issue && op == `IDP_OP_CACC && cond_val == 32'h0);
endmodule // idp_monitor

bind idp_datapath idp_monitor idp_monitor_inst (
  .ref_clk(ref_clk), .rst_n(rst_n), .issue(issue), .op(op), .src_a(src_a), .src_b(src_b),
  .cond_val(cond_val), .frac_shift(frac_shift), .round_en(round_en),
  .flag_clear(flag_clear), .result(result), .result_valid(result_valid),
  .overflow(overflow), .near_overflow_flag(near_overflow_flag),
  .sticky_near_overflow_flag(sticky_near_overflow_flag)
);

// file: verification/test_integer_dsp_alu_datapath.sv
// Self-checking bench for the integer datapath
`timescale 1ns/10ps
`include "idp_defines.vh"
module test_integer_dsp_alu_datapath;
  reg ref_clk;
  reg rst_n;
  wire issue, frac_shift, round_en, flag_clear, result_valid, overflow;
  wire near_overflow_flag, sticky_near_overflow_flag;
  wire [5:0] op, width;
  wire [31:0] src_a, src_b, src_c, cond_val, result;
  wire [4:0] pos;
  wire [3:0] konst;
  wire [1:0] mul_clamp;
  integer err_total, checked;
  idp_datapath idp_datapath_inst (
    .ref_clk(ref_clk), .rst_n(rst_n), .issue(issue), .op(op), .src_a(src_a),
    .src_b(src_b), .src_c(src_c), .cond_val(cond_val), .pos(pos), .width(width),
    .konst(konst), .frac_shift(frac_shift), .round_en(round_en), .mul_clamp(mul_clamp),
    .flag_clear(flag_clear), .result(result), .result_valid(result_valid),
    .overflow(overflow), .near_overflow_flag(near_overflow_flag),
    .sticky_near_overflow_flag(sticky_near_overflow_flag)
  );
  idp_core_model cm (
    .ref_clk(ref_clk), .result(result), .result_valid(result_valid), .issue(issue),
    .op(op), .src_a(src_a), .src_b(src_b), .src_c(src_c), .cond_val(cond_val),
    .pos(pos), .width(width), .konst(konst), .frac_shift(frac_shift),
    .round_en(round_en), .mul_clamp(mul_clamp), .flag_clear(flag_clear)
  );
  ////////////////////////////////////////
  task check(input [8*9-1:0] what, input [31:0] seen, input [31:0] exp);
    begin
      checked = checked + 1;
      if (seen !== exp) begin
        err_total = err_total + 1;
        $display("unexpected %0s: expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  task run(input [5:0] o, input [31:0] a, input [31:0] b, input [31:0] e);
    begin
      cm.go(o, a, b);
      check("result", cm.res, e);
    end
  endtask
  task t_arith;
    begin
      run(`IDP_OP_MAG, 32'hfffffffb, 32'h0, 32'h5);
      run(`IDP_OP_MAG_CLAMP, `IDP_SMIN32, 32'h0, `IDP_SMAX32);
      run(`IDP_OP_DMAG, 32'h3, 32'ha, 32'h7);
      run(`IDP_OP_DMAG_CLAMP, `IDP_SMAX32, `IDP_SMIN32, `IDP_SMAX32);
      run(`IDP_OP_MIN, 32'hffffffff, 32'h1, 32'hffffffff);
      run(`IDP_OP_MIN_U, 32'hffffffff, 32'h1, 32'h1);
      run(`IDP_OP_MAX, 32'hffffffff, 32'h1, 32'h1);
      run(`IDP_OP_MAX_U, 32'hffffffff, 32'h1, 32'hffffffff);
      run(`IDP_OP_CLAMP_B, 32'hfffffed4, 32'h0, `IDP_SMIN8);
      run(`IDP_OP_CLAMP_BU, 32'h1234, 32'h0, `IDP_UMAX8);
      run(`IDP_OP_CLAMP_H, 32'h12345, 32'h0, `IDP_SMAX16);
      run(`IDP_OP_CLAMP_HU, 32'h12345, 32'h0, `IDP_UMAX16);
      $display("t_arith done");
    end
  endtask
  task t_cond;
    integer k;
    begin
      for (k = 0; k < 2; k = k + 1) begin
        cm.cond_val = k ? 32'h100 : 32'h0;
        run(`IDP_OP_CACC, 32'ha, 32'h3, k ? 32'hd : 32'ha);
        run(`IDP_OP_CDED, 32'ha, 32'h3, k ? 32'h7 : 32'ha);
        run(`IDP_OP_CACC_F, 32'ha, 32'h3, k ? 32'ha : 32'hd);
        run(`IDP_OP_CDED_F, 32'ha, 32'h3, k ? 32'ha : 32'h7);
        run(`IDP_OP_SELECT, 32'ha, 32'h3, k ? 32'ha : 32'h3);
      end
      $display("t_cond done");
    end
  endtask
  task t_logic;
    reg [31:0] a, b, e;
    integer k;
    begin
      a = 32'hf0f0f0f0;
      b = 32'hff00ff00;
      for (k = 0; k < 8; k = k + 1) begin
        case (k)
          0: e = a & b;
          1: e = a | b;
          2: e = a ^ b;
          3: e = ~(a & b);
          4: e = ~(a | b);
          5: e = ~(a ^ b);
          6: e = a & ~b;
          default: e = a | ~b;
        endcase
        run(`IDP_OP_AND + k[5:0], a, b, e);
      end
      $display("t_logic done");
    end
  endtask
  task t_count;
    begin
      run(`IDP_OP_LZC, 32'h01ffffff, 32'h0, 32'h7);
      run(`IDP_OP_LZC, 32'h80000000, 32'h0, 32'h0);
      run(`IDP_OP_LZC, 32'h0, 32'h0, 32'h20);
      run(`IDP_OP_LOC, 32'hf0000000, 32'h0, 32'h4);
      run(`IDP_OP_LOC, 32'hffffffff, 32'h0, 32'h20);
      run(`IDP_OP_RSC, 32'h00ff0000, 32'h0, 32'h7);
      run(`IDP_OP_RSC, 32'h0, 32'h0, 32'h1f);
      run(`IDP_OP_RSC, 32'hffffffff, 32'h0, 32'h1f);
      $display("t_count done");
    end
  endtask
  task t_shift;
    begin
      run(`IDP_OP_LSH, 32'h80000001, 32'h4, 32'h10);
      run(`IDP_OP_LSH, 32'h80000001, 32'hfffffffc, 32'h08000000);
      run(`IDP_OP_LSH, 32'h1, 32'h21, 32'h2);
      run(`IDP_OP_LSH, 32'h1234, 32'hffffffe0, 32'h1234);
      run(`IDP_OP_ASH, 32'h80000000, 32'hfffffffc, 32'hf8000000);
      run(`IDP_OP_ASH, 32'hc0000001, 32'h1, 32'h80000002);
      run(`IDP_OP_ASH_CLAMP, 32'h40000000, 32'h1, `IDP_SMAX32);
      run(`IDP_OP_ASH_CLAMP, 32'hb0000000, 32'h2, `IDP_SMIN32);
      run(`IDP_OP_ASH_CLAMP, 32'hf0000001, 32'h3, 32'h80000008);
      $display("t_shift done");
    end
  endtask
  task t_field;
    begin
      cm.late = 1'b1;
      cm.pos = 5'h8;
      cm.width = 6'h8;
      run(`IDP_OP_PULL_U, 32'habcd1234, 32'h0, 32'h12);
      run(`IDP_OP_WINDOW, 32'h12345678, 32'h9abcdef0, 32'h3456789a);
      run(`IDP_OP_INSERT, 32'h0, 32'hffffffff, 32'h0000ff00);
      cm.pos = 5'hc;
      cm.width = 6'h4;
      run(`IDP_OP_PULL_S, 32'h0000f000, 32'h0, 32'hffffffff);
      run(`IDP_OP_WINDOW, 32'h80000001, 32'h80000001, 32'h00001800);
      cm.pos = 5'h1c;
      cm.konst = 4'h5;
      run(`IDP_OP_INSERT_K, 32'hffffffff, 32'h0, 32'h5fffffff);
      cm.pos = 5'h0;
      cm.width = 6'h20;
      run(`IDP_OP_PULL_U, 32'hfedcba98, 32'h0, 32'hfedcba98);
      cm.late = 1'b0;
      $display("t_field done");
    end
  endtask
  task t_frac;
    begin
      cm.frac_shift = 1'b1;
      run(`IDP_OP_QMUL, `IDP_SMIN32, `IDP_SMIN32, `IDP_SMAX32);
      check("overflow", {31'h0, overflow}, 32'h0);
      check("near", {31'h0, near_overflow_flag}, 32'h1);
      run(`IDP_OP_QMUL, 32'hc0000000, 32'h40000000, 32'he0000000);
      cm.round_en = 1'b1;
      run(`IDP_OP_QMUL, 32'h40000000, 32'h00018000, 32'h00010000);
      cm.round_en = 1'b0;
      cm.mul_clamp = `IDP_MUL_CLAMP_U;
      run(`IDP_OP_QMUL, 32'hc0000000, 32'h40000000, 32'h0);
      check("overflow", {31'h0, overflow}, 32'h1);
      cm.mul_clamp = `IDP_MUL_CLAMP_S;
      cm.src_c = 32'h7fff0000;
      run(`IDP_OP_QMAC, 32'h40000000, 32'h40000000, `IDP_SMAX32);
      cm.src_c = `IDP_SMIN32;
      run(`IDP_OP_QMSB, 32'h40000000, 32'h40000000, `IDP_SMIN32);
      cm.frac_shift = 1'b0;
      run(`IDP_OP_QMUL, `IDP_SMIN32, `IDP_SMIN32, 32'h40000000);
      run(`IDP_OP_AND, 32'h0, 32'h0, 32'h0);
      check("sticky", {31'h0, sticky_near_overflow_flag}, 32'h1);
      cm.flag_clear = 1'b1;
      run(`IDP_OP_AND, 32'h0, 32'h0, 32'h0);
      cm.flag_clear = 1'b0;
      check("sticky", {31'h0, sticky_near_overflow_flag}, 32'h0);
      $display("t_frac done");
    end
  endtask
  task wrap_up;
    begin
      $display("checked %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  ////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  initial begin
    err_total = 0;
    checked = 0;
    cm.init;
    rst_n = 1'b0;
    repeat (10) @(negedge ref_clk);
    rst_n = 1'b1;
    t_arith;
    t_cond;
    t_logic;
    t_count;
    t_shift;
    t_field;
    t_frac;
    wrap_up;
  end
  // 63 operations of at most four cycles each
  initial begin
    #20000;
    err_total = err_total + 1;
    wrap_up;
  end
endmodule // test_integer_dsp_alu_datapath
